// ---- shared/fpec_pkg.sv ----
package fpec_pkg;

  // byte offsets of the register words on the bus
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_KEY = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h10;

  // control register field positions
  localparam int CTRL_GO_BIT = 15;
  localparam int CTRL_PROGRAM_ENABLE_BIT_BIT = 14;
  localparam int CTRL_FAULT_BIT = 13;
  localparam int CTRL_ERASE_BIT = 6;
  localparam int CTRL_OPSEL_LSB = 0;
  localparam int OPSEL_W = 4;

  // key register field
  localparam int KEY_LSB = 0;
  localparam int KEY_W = 8;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // interrupt status bit positions
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  localparam int IRQ_W = 2;

  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [1:0] IRQ_EN_RST = 2'h0;

  // operation select codes
  localparam logic [3:0] OPSEL_BULK = 4'hF;
  localparam logic [3:0] OPSEL_SEG_GEN = 4'hD;
  localparam logic [3:0] OPSEL_SEG_SEC = 4'hC;
  localparam logic [3:0] OPSEL_WORD = 4'h3;
  localparam logic [3:0] OPSEL_PAGE = 4'h2;
  localparam logic [3:0] OPSEL_ROW = 4'h1;
  localparam logic [3:0] OPSEL_CFG = 4'h0;

  // self-timed operation length, least time so rounded up
  localparam int CLK_PERIOD_NS = 40;
  localparam int OP_TIME_NS = 20000;
  localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  typedef enum logic [1:0] {
    FPEC_KEY_IDLE,
    FPEC_KEY_HALF,
    FPEC_KEY_ARMED
  } fpec_key_t;

  typedef enum logic [3:0] {
    FPEC_OP_NONE,
    FPEC_OP_BULK_ERASE,
    FPEC_OP_PAGE_ERASE,
    FPEC_OP_CFG_ERASE,
    FPEC_OP_SEG_GEN_ERASE,
    FPEC_OP_SEG_SEC_ERASE,
    FPEC_OP_WORD_PROG,
    FPEC_OP_ROW_PROG,
    FPEC_OP_CFG_PROG
  } fpec_op_t;

endpackage

// ---- shared/fpec_op_if.sv ----
`timescale 1ns/1ps
interface fpec_op_if;
  logic start; // one-cycle pulse, begin timing
  logic abort; // one-cycle pulse, end timing early
  logic busy; // timer running
  logic done; // one-cycle pulse, normal end

  modport ctl (output start, output abort, input busy, input done);
  modport tmr (input start, input abort, output busy, output done);
endinterface

// ---- core/fpec_timer.sv ----
`timescale 1ns/1ps
module fpec_timer (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  fpec_op_if.tmr op // start and finish of one operation
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [fpec_pkg::CNT_W-1:0] cnt;
  } fpec_tmr_state_t;

  localparam logic [fpec_pkg::CNT_W-1:0] LOAD = fpec_pkg::CNT_W'(fpec_pkg::OP_CYCLES - 1);

  fpec_tmr_state_t r;
  fpec_tmr_state_t s;

  // count down the self-timed operation; abort wins over start and done
  always_comb begin
    s = r;
    s.done = 1'b0;
    if (op.abort) begin
      s.busy = 1'b0;
      s.cnt = '0;
    end else if (op.start && !r.busy) begin
      s.busy = 1'b1;
      s.cnt = LOAD;
    end else if (r.busy) begin
      if (r.cnt == '0) begin
        s.busy = 1'b0;
        s.done = 1'b1;
      end else begin
        s.cnt = r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= s;
    end
  end

  assign op.busy = r.busy;
  assign op.done = r.done;

endmodule

// ---- core/fpec_top.sv ----
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - erase bit picks decode of select field
// - erase codes: bulk, page, config, two segments
// - program codes: word, row, config byte
// - unlisted select codes perform no operation
// - key takes low byte, never reads back
// - key bits fifteen to eight read zero
// - unimplemented control bits read zero
// - processor stalls while operation runs
module fpec_top (
  input wire logic hclk, // system clock, 25 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word transfers only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic flash_abort, // async pin, ends operation early
  output logic flash_start, // one-cycle pulse to the array
  output logic [3:0] flash_op, // operation kind to the array
  output logic flash_busy, // operation running
  output logic irq // level interrupt
);

  typedef struct packed {
    logic dp_valid;
    logic dp_write;
    logic dp_hit;
    logic [7:0] dp_addr;
    logic rdy;
    logic [31:0] rdata;
    logic go;
    logic program_enable_bit;
    logic fault;
    logic erase;
    logic [3:0] opsel;
    fpec_pkg::fpec_key_t key;
    logic [1:0] irq_sts;
    logic [1:0] irq_en;
    logic irq;
    logic [2:0] abort_sync;
    logic abort_lvl;
    logic start;
    logic abort;
    fpec_pkg::fpec_op_t op;
    logic busy;
  } fpec_state_t;

  fpec_state_t r;
  fpec_state_t s;

  fpec_op_if op_bus ();

  fpec_timer u_timer (
    .clk(hclk),
    .rst_n(hresetn),
    .op(op_bus.tmr)
  );

  // map the mode bit and select code onto an operation kind
  function automatic fpec_pkg::fpec_op_t fpec_decode(
    input logic erase,
    input logic [3:0] sel
  );
    fpec_pkg::fpec_op_t k;
    k = fpec_pkg::FPEC_OP_NONE;
    if (erase) begin
      case (sel)
        fpec_pkg::OPSEL_BULK: k = fpec_pkg::FPEC_OP_BULK_ERASE;
        fpec_pkg::OPSEL_PAGE: k = fpec_pkg::FPEC_OP_PAGE_ERASE;
        fpec_pkg::OPSEL_CFG: k = fpec_pkg::FPEC_OP_CFG_ERASE;
        fpec_pkg::OPSEL_SEG_GEN: k = fpec_pkg::FPEC_OP_SEG_GEN_ERASE;
        fpec_pkg::OPSEL_SEG_SEC: k = fpec_pkg::FPEC_OP_SEG_SEC_ERASE;
        default: k = fpec_pkg::FPEC_OP_NONE;
      endcase
    end else begin
      case (sel)
        fpec_pkg::OPSEL_WORD: k = fpec_pkg::FPEC_OP_WORD_PROG;
        fpec_pkg::OPSEL_ROW: k = fpec_pkg::FPEC_OP_ROW_PROG;
        fpec_pkg::OPSEL_CFG: k = fpec_pkg::FPEC_OP_CFG_PROG;
        default: k = fpec_pkg::FPEC_OP_NONE;
      endcase
    end
    return k;
  endfunction

  // next state of the whole block
  always_comb begin
    logic ev_done;
    logic ev_fault;
    logic [1:0] ev_bits;
    logic [31:0] rd;
    fpec_pkg::fpec_op_t dec;
    ev_done = 1'b0;
    ev_fault = 1'b0;
    ev_bits = '0;
    rd = '0;
    dec = fpec_pkg::FPEC_OP_NONE;
    s = r;
    s.start = 1'b0;
    s.abort = 1'b0;

    // abort pin: first stage feeds only the second
    s.abort_sync = {r.abort_sync[1:0], flash_abort};
    if (r.abort_sync[2] == r.abort_sync[1]) begin
      s.abort_lvl = r.abort_sync[2];
    end

    // normal end: go drops and the fault flag reads clear
    if (op_bus.done) begin
      ev_done = 1'b1;
      s.go = 1'b0;
      s.fault = 1'b0;
      s.busy = 1'b0;
    end else if (s.abort_lvl && !r.abort_lvl && r.go) begin
      // early end is a sequence fault
      ev_fault = 1'b1;
      s.abort = 1'b1;
      s.go = 1'b0;
      s.fault = 1'b1;
      s.busy = 1'b0;
    end

    // data phase completes on the edge where hreadyout is high
    if (r.dp_valid && r.rdy) begin
      s.dp_valid = 1'b0;
      if (r.dp_write && r.dp_hit) begin
        // any write elsewhere breaks the unlock pair
        if (r.dp_addr != fpec_pkg::ADDR_KEY) begin
          s.key = fpec_pkg::FPEC_KEY_IDLE;
        end
        case (r.dp_addr)
          fpec_pkg::ADDR_CTRL: begin
            s.program_enable_bit = hwdata[fpec_pkg::CTRL_PROGRAM_ENABLE_BIT_BIT];
            s.erase = hwdata[fpec_pkg::CTRL_ERASE_BIT];
            s.opsel = hwdata[fpec_pkg::CTRL_OPSEL_LSB +: fpec_pkg::OPSEL_W];
            // a fault raised this cycle survives a clearing write
            s.fault = hwdata[fpec_pkg::CTRL_FAULT_BIT] | ev_fault;
            // go is set only, and only from idle
            if (hwdata[fpec_pkg::CTRL_GO_BIT] && !r.go
                && hwdata[fpec_pkg::CTRL_PROGRAM_ENABLE_BIT_BIT]) begin
              if (r.key != fpec_pkg::FPEC_KEY_ARMED) begin
                s.fault = 1'b1;
                ev_fault = 1'b1;
              end else begin
                dec = fpec_decode(hwdata[fpec_pkg::CTRL_ERASE_BIT],
                  hwdata[fpec_pkg::CTRL_OPSEL_LSB +: fpec_pkg::OPSEL_W]);
                if (dec != fpec_pkg::FPEC_OP_NONE) begin
                  s.go = 1'b1;
                  s.start = 1'b1;
                  s.busy = 1'b1;
                  s.op = dec;
                end
              end
            end
          end
          fpec_pkg::ADDR_KEY: begin
            // two consecutive writes arm the start
            if (hwdata[fpec_pkg::KEY_LSB +: fpec_pkg::KEY_W] == fpec_pkg::KEY_FIRST) begin
              s.key = fpec_pkg::FPEC_KEY_HALF;
            end else if (r.key == fpec_pkg::FPEC_KEY_HALF
                && hwdata[fpec_pkg::KEY_LSB +: fpec_pkg::KEY_W]
                == fpec_pkg::KEY_SECOND) begin
              s.key = fpec_pkg::FPEC_KEY_ARMED;
            end else begin
              s.key = fpec_pkg::FPEC_KEY_IDLE;
            end
          end
          fpec_pkg::ADDR_IRQ_EN: begin
            s.irq_en = hwdata[fpec_pkg::IRQ_W-1:0];
          end
          default: begin
          end
        endcase
      end
    end

    // sticky status: setting wins over a clear in the same cycle
    ev_bits[fpec_pkg::IRQ_DONE_BIT] = ev_done;
    ev_bits[fpec_pkg::IRQ_FAULT_BIT] = ev_fault;
    if (r.dp_valid && r.rdy && r.dp_write && r.dp_hit
        && r.dp_addr == fpec_pkg::ADDR_IRQ_CLR) begin
      s.irq_sts = (r.irq_sts & ~hwdata[fpec_pkg::IRQ_W-1:0]) | ev_bits;
    end else begin
      s.irq_sts = r.irq_sts | ev_bits;
    end

    // read view; key and unused bits always read zero
    rd[fpec_pkg::CTRL_GO_BIT] = s.go;
    rd[fpec_pkg::CTRL_PROGRAM_ENABLE_BIT_BIT] = s.program_enable_bit;
    rd[fpec_pkg::CTRL_FAULT_BIT] = s.fault;
    rd[fpec_pkg::CTRL_ERASE_BIT] = s.erase;
    rd[fpec_pkg::CTRL_OPSEL_LSB +: fpec_pkg::OPSEL_W] = s.opsel;
    if (!r.dp_hit) begin
      rd = '0;
    end else begin
      case (r.dp_addr)
        fpec_pkg::ADDR_CTRL: begin
        end
        fpec_pkg::ADDR_IRQ_STS: rd = {30'h0, s.irq_sts};
        fpec_pkg::ADDR_IRQ_EN: rd = {30'h0, s.irq_en};
        default: rd = '0;
      endcase
    end

    // address phase; one wait state, held low while an operation runs
    if (hready && hsel && htrans[1]) begin
      s.dp_valid = 1'b1;
      s.dp_write = hwrite;
      s.dp_hit = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
      s.dp_addr = haddr[7:0];
      s.rdy = 1'b0;
    end else if (r.dp_valid && !r.rdy && !s.go) begin
      s.rdy = 1'b1;
      if (!r.dp_write) begin
        s.rdata = rd;
      end
    end

    s.irq = |(s.irq_sts & s.irq_en);
  end

  // one register for all state; hreadyout idles high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.rdy <= 1'b1;
      r.program_enable_bit <= fpec_pkg::CTRL_RST[fpec_pkg::CTRL_PROGRAM_ENABLE_BIT_BIT];
      r.irq_en <= fpec_pkg::IRQ_EN_RST;
    end else begin
      r <= s;
    end
  end

  assign op_bus.start = r.start;
  assign op_bus.abort = r.abort;

  // outputs straight from the state register; hresp is tied to okay
  assign hreadyout = r.rdy;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign flash_start = r.start;
  assign flash_op = r.op;
  assign flash_busy = r.busy;
  assign irq = r.irq;

endmodule

// ---- dv/fpec_top_asserts.sv ----
`timescale 1ns/1ps
module fpec_top_asserts (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic hsel, // select
  input wire logic [1:0] htrans, // transfer type
  input wire logic hready, // bus ready
  input wire logic hreadyout, // slave ready
  input wire logic hresp, // response
  input wire logic [31:0] hrdata, // read data
  input wire logic flash_abort, // early end pin
  input wire logic flash_start, // start pulse
  input wire logic [3:0] flash_op, // operation kind
  input wire logic flash_busy // operation running
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // busy covers the start edge, the timer's whole count and the edge that sees done
  localparam logic [9:0] BUSY_LEN = 10'(fpec_pkg::OP_CYCLES + 2);
  logic [9:0] bc_r;
  logic ab_r;
  // busy length, and whether an abort came, so an early end is told apart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bc_r <= 10'h000;
      ab_r <= 1'h0;
    end else begin
      bc_r <= flash_busy ? bc_r + 10'h001 : 10'h000;
      ab_r <= flash_busy & (ab_r | flash_abort);
    end
  end
  a_resp_okay: assert property (hresp == 1'h0) else $error("response not okay");
  a_wait_state: assert property (hready && hsel && htrans[1] |=> !hreadyout)
    else $error("transfer taken without wait state");
  a_stall_held: assert property (flash_busy && !hreadyout ##1 flash_busy[*2]
    |-> $past(hreadyout) == 1'h0) else $error("stall released while busy");
  a_start_pulse: assert property (flash_start |=> !flash_start)
    else $error("start pulse too long");
  a_start_busy: assert property (flash_start |-> ##[0:1] flash_busy)
    else $error("start without busy");
  a_op_changes: assert property ($changed(flash_op) |-> flash_start)
    else $error("operation kind moved without start");
  a_op_valid: assert property (flash_start |-> flash_op inside {[4'h1:4'h8]})
    else $error("start with no operation");
  a_busy_len: assert property ($fell(flash_busy) |-> ab_r || bc_r == BUSY_LEN)
    else $error("operation length wrong");
  a_busy_max: assert property (flash_busy |-> bc_r < BUSY_LEN)
    else $error("operation overran");
  a_rdata_upper: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
endmodule
bind fpec_top fpec_top_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .flash_abort(flash_abort), .flash_start(flash_start),
  .flash_op(flash_op), .flash_busy(flash_busy));

// ---- dv/test_fpec_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module test_fpec_top;
  localparam logic [7:0] CT = fpec_pkg::ADDR_CTRL;
  localparam logic [7:0] KY = fpec_pkg::ADDR_KEY;
  localparam logic [7:0] ST = fpec_pkg::ADDR_IRQ_STS;
  localparam logic [7:0] CL = fpec_pkg::ADDR_IRQ_CLR;
  localparam logic [7:0] EN = fpec_pkg::ADDR_IRQ_EN;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic flash_abort = 1'h0, rd_ph = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, flash_start, flash_busy, irq;
  logic [3:0] flash_op;
  int checks = 0, error_cnt = 0;
  logic [31:0] rq[$];
  logic [3:0] oq[$];
  logic [31:0] exp_d;
  logic [3:0] exp_o;
  fpec_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flash_abort(flash_abort),
    .flash_start(flash_start), .flash_op(flash_op), .flash_busy(flash_busy), .irq(irq));
  initial forever #20 hclk = ~hclk;
  // one transfer; wait states counted by the bus, never assumed
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd_ph <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    xf(1'h0, a, 32'h0);
  endtask
  // junk above the key byte must not spoil the unlock
  task automatic unl;
    wr(KY, ($urandom & 32'hFF00) | 32'h55);
    wr(KY, 32'hAA);
  endtask
  function automatic logic [3:0] op_of(input logic e, input logic [3:0] c);
    case ({e, c})
      5'h1F: op_of = 4'h1;
      5'h12: op_of = 4'h2;
      5'h10: op_of = 4'h3;
      5'h1D: op_of = 4'h4;
      5'h1C: op_of = 4'h5;
      5'h03: op_of = 4'h6;
      5'h01: op_of = 4'h7;
      5'h00: op_of = 4'h8;
      default: op_of = 4'h0;
    endcase
  endfunction
  // results appear as read data and as start pulses; an unplanned start meets 0
  // notes are popped once into a variable, since the macro reads its argument twice
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) begin
      exp_d = rq.pop_front();
      `CHK(hrdata, exp_d)
    end
    if (flash_start) begin
      exp_o = oq.size() ? oq.pop_front() : 4'h0;
      `CHK(flash_op, exp_o)
    end
  end
  task automatic results;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #800000;
    error_cnt++;
    results();
  end
  initial begin
    logic e;
    logic [3:0] c, x;
    time t0;
    void'($urandom(32'h6CBF));
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(CT, 32'h0);
    rd(ST, 32'h0);
    rd(EN, 32'h0);
    wr(KY, 32'hFFFF);
    rd(KY, 32'h0);
    wr(8'h40, $urandom);
    rd(8'h40, 32'h0);
    wr(EN, 32'h3);
    rd(EN, 32'h3);
    $display("test registers done");
    // every code in both modes, with junk in the unimplemented bits
    for (int i = 0; i < 32; i++) begin
      e = i[4];
      c = i[3:0];
      x = op_of(e, c);
      unl();
      if (x != 4'h0) oq.push_back(x);
      wr(CT, {16'h0, 16'hC000 | {9'h0, e, 2'h0, c}} | ($urandom & 32'h1FB0));
      t0 = $time;
      rd(CT, {16'h0, 16'h4000 | {9'h0, e, 2'h0, c}});
      if (x != 4'h0) `CHK($time - t0 >= 20000, 1'h1)
      rd(ST, {31'h0, x != 4'h0});
      `CHK(irq, x != 4'h0)
      wr(CL, 32'h3);
    end
    $display("test codes done");
    wr(CT, 32'hC042);
    rd(CT, 32'h6042);
    rd(ST, 32'h2);
    wr(CT, 32'h0042);
    wr(KY, 32'h55);
    wr(EN, 32'h3);
    wr(KY, 32'hAA);
    wr(CT, 32'hC042);
    rd(CT, 32'h6042);
    wr(CT, 32'h0);
    wr(CL, 32'h3);
    unl();
    wr(CT, 32'h8042);
    rd(CT, 32'h0042);
    rd(ST, 32'h0);
    $display("test faults done");
    unl();
    oq.push_back(4'h2);
    wr(CT, 32'hC042);
    repeat (50) @(posedge hclk);
    flash_abort <= 1'h1;
    repeat (4) @(posedge hclk);
    flash_abort <= 1'h0;
    rd(CT, 32'h6042);
    rd(ST, 32'h2);
    wr(EN, 32'h0);
    rd(EN, 32'h0);
    `CHK(irq, 1'h0)
    wr(CL, 32'h3);
    rd(ST, 32'h0);
    // a normal end clears a fault flag that was set by the starting write
    unl();
    oq.push_back(4'h6);
    wr(CT, 32'hE003);
    rd(CT, 32'h4003);
    rd(ST, 32'h1);
    $display("test abort done");
    results();
  end
endmodule
